// >>> hdl/pmcf_map.svh
`ifndef PMCF_MAP_SVH
`define PMCF_MAP_SVH
// ****************************************
// Command codes
// ****************************************
`define PMCF_ADDR_SCRATCH 8'hd0
`define PMCF_ADDR_DELAY 8'hd1
`define PMCF_ADDR_MODE 8'hd2
`define PMCF_ADDR_FREQ 8'hd3
`define PMCF_ADDR_TRIM 8'hd4
// ****************************************
// Field positions
// ****************************************
`define PMCF_WORD_MSB 5
`define PMCF_GOOD_MSB 5
`define PMCF_GOOD_LSB 3
`define PMCF_POD_MSB 2
`define PMCF_RAMP_MSB 3
`define PMCF_RAMP_LSB 2
`define PMCF_UVRESP_BIT 1
`define PMCF_COND_BIT 0
`define PMCF_FREQ_MSB 2
`define PMCF_TRIM_MSB 4
// ****************************************
// Reset values
// ****************************************
`define PMCF_RST_WORD 6'h00
`define PMCF_RST_GOOD 3'h2
`define PMCF_RST_POD 3'h2
`define PMCF_RST_RAMP 2'h0
`define PMCF_RST_UVRESP 1'h0
`define PMCF_RST_COND 1'h0
`define PMCF_RST_FREQ 3'h2
`define PMCF_RST_TRIM 5'h10
// ****************************************
// Timing, in microseconds
// ****************************************
`define PMCF_CLK_MHZ 10
`define PMCF_GOOD_BASE_US 24'd256
`define PMCF_GOOD_LONG_US 24'd131072
`define PMCF_POD_OFFS_US 24'd100
`define PMCF_POD_BASE_US 24'd256
`define PMCF_RAMP_BASE_US 24'd1000
`define PMCF_HICCUP_US 24'd8960
`define PMCF_HICCUP_RAMPS 24'd7
// ****************************************
// Trim scaling, Q2.14
// ****************************************
`define PMCF_SCALE_ONE 16'h4000
`define PMCF_TRIM_STEP 16'h007b
`define PMCF_TRIM_MAX 5'h0c
`define PMCF_TRIM_ZERO 5'h10
`define PMCF_SCALE_FRAC 14
`define PMCF_FAULT_N 4
`endif

// >>> hdl/pmcf_pkg.sv
package pmcf_pkg;
  // Converter sequencing states, one-hot
  typedef enum logic [6:0] {
    PMCF_OFF     = 7'h01,
    PMCF_PWRON   = 7'h02,
    PMCF_RAMP    = 7'h04,
    PMCF_GOODDLY = 7'h08,
    PMCF_RUN     = 7'h10,
    PMCF_HICCUP  = 7'h20,
    PMCF_LATCHED = 7'h40
  } pmcf_state_e;
  typedef logic [23:0] pmcf_us_t;
endpackage

// >>> hdl/pmcf_regs.sv
`timescale 1ns/1ps
`include "pmcf_map.svh"
// What this block does
// - Fault flags held until clear, restart, reset
// - Condition still present re-sets flag at clear
// - Alert asserted while any flag is set
// - Scratch register holds six free bits
// - Good delay from bits 5:3
// - Power-on delay from bits 2:0
// - Ramp time from mode bits 3:2
// - Undervoltage: hiccup restart or latch off
// - Discontinuous during ramp, continuous if selected
// - Switching frequency from bits 2:0
// - Output trim in 0.75 percent steps
// - Trim and margin scales are multiplied
// - Unimplemented upper bits ignored, read zero
// - Flags latch on condition, stay set until clear, restart or reset
module pmcf_regs import pmcf_pkg::*; #(
  parameter int US_CYCLES = `PMCF_CLK_MHZ
) (
  input wire logic sys_clk_i,
  input wire logic srst_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic reg_wr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_rd_i,
  output logic [7:0] reg_rdata_o,
  output logic reg_rvalid_o,
  input wire logic clear_faults_i,
  input wire logic en_i,
  input wire logic [`PMCF_FAULT_N-1:0] fault_cond_i,
  input wire logic uv_cond_i,
  input wire logic [15:0] margin_scale_i,
  output logic [`PMCF_FAULT_N-1:0] fault_flags_o,
  output logic alert_o,
  output logic switching_o,
  output logic fccm_o,
  output logic pgood_o,
  output logic [2:0] freq_select_o,
  output logic [15:0] vref_scale_o
);
  // ****************************************
  // Configuration registers
  // ****************************************
  logic [5:0] user_word;
  logic [2:0] good_delay_sel;
  logic [2:0] poweron_delay_sel;
  logic [1:0] ramp_time_sel;
  logic undervolt_response;
  logic conduction_select;
  logic [2:0] freq_select;
  logic [4:0] trim_code;
  logic [7:0] next_rdata;

  // Byte writes store only implemented bits
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      user_word <= `PMCF_RST_WORD;
      good_delay_sel <= `PMCF_RST_GOOD;
      poweron_delay_sel <= `PMCF_RST_POD;
      ramp_time_sel <= `PMCF_RST_RAMP;
      undervolt_response <= `PMCF_RST_UVRESP;
      conduction_select <= `PMCF_RST_COND;
      freq_select <= `PMCF_RST_FREQ;
      trim_code <= `PMCF_RST_TRIM;
    end else if (reg_wr_i) begin
      unique case (reg_addr_i)
        `PMCF_ADDR_SCRATCH: user_word <= reg_wdata_i[`PMCF_WORD_MSB:0];
        `PMCF_ADDR_DELAY: begin
          good_delay_sel <= reg_wdata_i[`PMCF_GOOD_MSB:`PMCF_GOOD_LSB];
          poweron_delay_sel <= reg_wdata_i[`PMCF_POD_MSB:0];
        end
        `PMCF_ADDR_MODE: begin
          ramp_time_sel <= reg_wdata_i[`PMCF_RAMP_MSB:`PMCF_RAMP_LSB];
          undervolt_response <= reg_wdata_i[`PMCF_UVRESP_BIT];
          conduction_select <= reg_wdata_i[`PMCF_COND_BIT];
        end
        `PMCF_ADDR_FREQ: freq_select <= reg_wdata_i[`PMCF_FREQ_MSB:0];
        `PMCF_ADDR_TRIM: trim_code <= reg_wdata_i[`PMCF_TRIM_MSB:0];
        default: ;
      endcase
    end
  end

  // Read mux, upper bits read as zero
  always_comb begin
    next_rdata = 8'h00;
    unique case (reg_addr_i)
      `PMCF_ADDR_SCRATCH: next_rdata = {2'h0, user_word};
      `PMCF_ADDR_DELAY: next_rdata = {2'h0, good_delay_sel, poweron_delay_sel};
      `PMCF_ADDR_MODE: next_rdata = {4'h0, ramp_time_sel, undervolt_response,
                                     conduction_select};
      `PMCF_ADDR_FREQ: next_rdata = {5'h00, freq_select};
      `PMCF_ADDR_TRIM: next_rdata = {3'h0, trim_code};
      default: next_rdata = 8'h00;
    endcase
  end

  // Registered read answer
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      reg_rdata_o <= 8'h00;
      reg_rvalid_o <= 1'b0;
    end else begin
      reg_rvalid_o <= reg_rd_i;
      if (reg_rd_i) begin
        reg_rdata_o <= next_rdata;
      end
    end
  end

  // ****************************************
  // Fault flags and alert
  // ****************************************
  logic en_q;
  logic restart;
  assign restart = en_i & ~en_q;

  // Enable history for off-then-on detection
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      en_q <= 1'b0;
    end else begin
      en_q <= en_i;
    end
  end

  // One latched flag per condition, set wins
  for (genvar g = 0; g < `PMCF_FAULT_N; g++) begin : g_flag
    always_ff @(posedge sys_clk_i) begin
      if (srst_i) begin
        fault_flags_o[g] <= 1'b0;
      end else if (fault_cond_i[g]) begin
        fault_flags_o[g] <= 1'b1;
      end else if (clear_faults_i || restart) begin
        fault_flags_o[g] <= 1'b0;
      end
    end
  end

  // Alert follows the flags; host services it as an interrupt
  assign alert_o = |fault_flags_o;

  // ****************************************
  // Sequencer timing
  // ****************************************
  pmcf_state_e state;
  pmcf_state_e next_state;
  pmcf_us_t us_cnt;
  pmcf_us_t pod_us;
  pmcf_us_t good_us;
  pmcf_us_t ramp_us;
  pmcf_us_t hiccup_us;
  logic [15:0] pre_cnt;
  logic us_tick;
  logic cnt_done;

  // Delay lookups in microseconds
  always_comb begin
    pod_us = `PMCF_POD_OFFS_US + (`PMCF_POD_BASE_US << poweron_delay_sel);
    good_us = (good_delay_sel == 3'h7) ? `PMCF_GOOD_LONG_US
            : (`PMCF_GOOD_BASE_US << good_delay_sel);
    ramp_us = `PMCF_RAMP_BASE_US << ramp_time_sel;
    hiccup_us = 24'(`PMCF_HICCUP_US + `PMCF_HICCUP_RAMPS * ramp_us);
  end

  // Microsecond prescaler
  always_ff @(posedge sys_clk_i) begin
    if (srst_i || us_tick) begin
      pre_cnt <= 16'h0000;
    end else begin
      pre_cnt <= pre_cnt + 16'h0001;
    end
  end
  assign us_tick = (pre_cnt == 16'(US_CYCLES - 1));
  assign cnt_done = us_tick && (us_cnt == 24'h000000);

  // State transitions
  always_comb begin
    next_state = state;
    unique case (state)
      PMCF_OFF: if (en_i) next_state = PMCF_PWRON;
      PMCF_PWRON: if (cnt_done) next_state = PMCF_RAMP;
      PMCF_RAMP: if (cnt_done) next_state = PMCF_GOODDLY;
      PMCF_GOODDLY: if (cnt_done) next_state = PMCF_RUN;
      PMCF_RUN: ;
      PMCF_HICCUP: if (cnt_done) next_state = PMCF_RAMP;
      PMCF_LATCHED: ;
    endcase
    if ((state & (PMCF_RAMP | PMCF_GOODDLY | PMCF_RUN)) != 7'h00 && uv_cond_i) begin
      next_state = undervolt_response ? PMCF_LATCHED : PMCF_HICCUP;
    end
    if (!en_i) begin
      next_state = PMCF_OFF;
    end
  end

  // State register and countdown load
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      state <= PMCF_OFF;
      us_cnt <= 24'h000000;
    end else begin
      state <= next_state;
      if (next_state != state) begin
        unique case (next_state)
          PMCF_PWRON: us_cnt <= pod_us - 24'h000001;
          PMCF_RAMP: us_cnt <= ramp_us - 24'h000001;
          PMCF_GOODDLY: us_cnt <= good_us - 24'h000001;
          PMCF_HICCUP: us_cnt <= hiccup_us - 24'h000001;
          default: us_cnt <= 24'h000000;
        endcase
      end else if (us_tick && us_cnt != 24'h000000) begin
        us_cnt <= us_cnt - 24'h000001;
      end
    end
  end

  // ****************************************
  // Converter controls
  // ****************************************
  logic [4:0] trim_steps;
  logic [15:0] trim_scale;
  logic [31:0] scale_prod;

  // Trim code to Q2.14 scale, clamped at 12 steps
  always_comb begin
    if (trim_code >= `PMCF_TRIM_ZERO) begin
      trim_steps = trim_code - `PMCF_TRIM_ZERO;
    end else begin
      trim_steps = 5'h0f - trim_code;
    end
    if (trim_steps > `PMCF_TRIM_MAX) begin
      trim_steps = `PMCF_TRIM_MAX;
    end
    if (trim_code >= `PMCF_TRIM_ZERO) begin
      trim_scale = 16'(`PMCF_SCALE_ONE + `PMCF_TRIM_STEP * trim_steps);
    end else begin
      trim_scale = 16'(`PMCF_SCALE_ONE - `PMCF_TRIM_STEP * trim_steps);
    end
    scale_prod = 32'(trim_scale) * 32'(margin_scale_i);
  end

  // Registered control outputs
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      switching_o <= 1'b0;
      fccm_o <= 1'b0;
      pgood_o <= 1'b0;
      freq_select_o <= `PMCF_RST_FREQ;
      vref_scale_o <= `PMCF_SCALE_ONE;
    end else begin
      switching_o <= (next_state & (PMCF_RAMP | PMCF_GOODDLY | PMCF_RUN)) != 7'h00;
      fccm_o <= conduction_select && (next_state == PMCF_GOODDLY ||
                                      next_state == PMCF_RUN);
      pgood_o <= (next_state == PMCF_RUN);
      freq_select_o <= freq_select;
      vref_scale_o <= scale_prod[`PMCF_SCALE_FRAC+15:`PMCF_SCALE_FRAC];
    end
  end

  // ****************************************
  // Assertions
  // ****************************************
  chk_flag_sets: assert property (@(posedge sys_clk_i) disable iff (srst_i)
    fault_cond_i[0] |=> fault_flags_o[0]) else $error("flag did not latch");
  chk_flag_holds: assert property (@(posedge sys_clk_i) disable iff (srst_i)
    fault_flags_o[0] && !clear_faults_i && !restart |=> fault_flags_o[0])
    else $error("flag dropped without clear");
  chk_clear_reset: assert property (@(posedge sys_clk_i) disable iff (srst_i)
    clear_faults_i && fault_cond_i[1] |=> fault_flags_o[1] && alert_o)
    else $error("present fault lost at clear");
  chk_clear_works: assert property (@(posedge sys_clk_i) disable iff (srst_i)
    clear_faults_i && fault_cond_i == '0 |=> !alert_o)
    else $error("clear did not release alert");
  chk_alert_flags: assert property (@(posedge sys_clk_i) disable iff (srst_i)
    alert_o == (fault_flags_o != '0)) else $error("alert mismatch");
  chk_scratch_rw: assert property (@(posedge sys_clk_i) disable iff (srst_i)
    reg_wr_i && reg_addr_i == `PMCF_ADDR_SCRATCH ##1 reg_rd_i && !reg_wr_i &&
    reg_addr_i == `PMCF_ADDR_SCRATCH |=> reg_rdata_o == {2'h0, $past(reg_wdata_i[5:0], 2)})
    else $error("scratch readback wrong");
  chk_upper_zero: assert property (@(posedge sys_clk_i) disable iff (srst_i)
    reg_rvalid_o && $past(reg_addr_i) == `PMCF_ADDR_MODE |-> reg_rdata_o[7:4] == 4'h0)
    else $error("upper bits not zero");
  chk_dcm_ramp: assert property (@(posedge sys_clk_i) disable iff (srst_i)
    $past(state) == PMCF_RAMP && state == PMCF_RAMP |-> !fccm_o)
    else $error("continuous mode during ramp");
  chk_uv_latch: assert property (@(posedge sys_clk_i) disable iff (srst_i)
    state == PMCF_RUN && uv_cond_i && en_i && undervolt_response
    |=> state == PMCF_LATCHED ##1 !switching_o) else $error("no latch-off on UV");
  chk_uv_hiccup: assert property (@(posedge sys_clk_i) disable iff (srst_i)
    state == PMCF_RUN && uv_cond_i && en_i && !undervolt_response
    |=> state == PMCF_HICCUP) else $error("no hiccup on UV");
endmodule

// >>> verif/pmcf_host.sv
`timescale 1ns/1ps
// Host on the register bus; counts alert edges as service requests
module pmcf_host (
  input wire logic sys_clk_i,
  input wire logic alert_i,
  input wire logic reg_rvalid_i,
  input wire logic [7:0] reg_rdata_i,
  output logic [7:0] reg_addr_o,
  output logic reg_wr_o,
  output logic [7:0] reg_wdata_o,
  output logic reg_rd_o,
  output int alert_events_o
);
  logic alert_q;
  // Idle bus at time zero
  initial begin
    reg_addr_o = 8'h00;
    reg_wr_o = 1'b0;
    reg_wdata_o = 8'h00;
    reg_rd_o = 1'b0;
    alert_events_o = 0;
    alert_q = 1'b0;
  end
  // Alert handled as an interrupt, no status polling
  always @(posedge sys_clk_i) begin
    alert_q <= alert_i;
    if (alert_i && !alert_q) alert_events_o <= alert_events_o + 1;
  end
  // Single byte write; upper bits sent as given
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk_i);
    reg_addr_o <= a;
    reg_wdata_o <= d;
    reg_wr_o <= 1'b1;
    @(posedge sys_clk_i);
    reg_wr_o <= 1'b0;
    reg_wdata_o <= ~d;
  endtask
  // Single byte read; data taken in the valid cycle
  task automatic rd_reg(input logic [7:0] a, output logic [7:0] d, output logic v);
    @(posedge sys_clk_i);
    reg_addr_o <= a;
    reg_rd_o <= 1'b1;
    @(posedge sys_clk_i);
    reg_rd_o <= 1'b0;
    reg_addr_o <= ~a;
    @(posedge sys_clk_i);
    v = reg_rvalid_i;
    d = reg_rdata_i;
  endtask
endmodule

// >>> verif/testbench.sv
`timescale 1ns/1ps
`include "pmcf_map.svh"
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin miscompares++; \
  $display("mismatch t=%0t got %h exp %h", $time, (g), (e)); end end
module testbench import pmcf_pkg::*;;
  logic sys_clk_i, srst_i, reg_wr_i, reg_rd_i, reg_rvalid_o, clear_faults_i, en_i, uv_cond_i;
  logic alert_o, switching_o, fccm_o, pgood_o, v;
  logic [7:0] reg_addr_i, reg_wdata_i, reg_rdata_o, d;
  logic [3:0] fault_cond_i, fault_flags_o;
  logic [15:0] margin_scale_i, vref_scale_o;
  logic [2:0] freq_select_o;
  int miscompares, checked, alerts, n;
  logic [7:0] adr [5] = '{`PMCF_ADDR_SCRATCH, `PMCF_ADDR_DELAY, `PMCF_ADDR_MODE,
    `PMCF_ADDR_FREQ, `PMCF_ADDR_TRIM};
  logic [7:0] dflt [5] = '{8'h00, 8'h12, 8'h00, 8'h02, 8'h10};
  logic [7:0] mask [5] = '{8'h3f, 8'h3f, 8'h0f, 8'h07, 8'h1f};
  // Device under test with microsecond of one cycle
  pmcf_regs #(.US_CYCLES(1)) dut_u (.sys_clk_i(sys_clk_i), .srst_i(srst_i),
    .reg_addr_i(reg_addr_i), .reg_wr_i(reg_wr_i), .reg_wdata_i(reg_wdata_i),
    .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .reg_rvalid_o(reg_rvalid_o),
    .clear_faults_i(clear_faults_i), .en_i(en_i), .fault_cond_i(fault_cond_i),
    .uv_cond_i(uv_cond_i), .margin_scale_i(margin_scale_i), .fault_flags_o(fault_flags_o),
    .alert_o(alert_o), .switching_o(switching_o), .fccm_o(fccm_o), .pgood_o(pgood_o),
    .freq_select_o(freq_select_o), .vref_scale_o(vref_scale_o));
  // Host model on the register bus
  pmcf_host host_u (.sys_clk_i(sys_clk_i), .alert_i(alert_o), .reg_rvalid_i(reg_rvalid_o),
    .reg_rdata_i(reg_rdata_o), .reg_addr_o(reg_addr_i), .reg_wr_o(reg_wr_i),
    .reg_wdata_o(reg_wdata_i), .reg_rd_o(reg_rd_i), .alert_events_o(alerts));
  // 10 MHz clock
  initial begin
    sys_clk_i = 1'b0;
    forever #50 sys_clk_i = ~sys_clk_i;
  end
  // Verdict and end of run
  task automatic summarize();
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  // Defaults of all registers and an unmapped read
  task automatic t_defaults();
    for (int i = 0; i < 5; i++) begin
      host_u.rd_reg(adr[i], d, v);
      `CHK({v, d}, {1'b1, dflt[i]})
    end
    host_u.rd_reg(8'hd7, d, v);
    `CHK(d, 8'h00)
    `CHK(freq_select_o, 3'h2)
  endtask
  // All ones written, only implemented bits kept
  task automatic t_rw();
    for (int i = 0; i < 5; i++) begin
      host_u.wr_reg(adr[i], 8'hff);
      host_u.rd_reg(adr[i], d, v);
      `CHK(d, mask[i])
    end
    `CHK(freq_select_o, 3'h7)
  endtask
  // Trim steps and product with margin
  task automatic t_trim();
    margin_scale_i <= 16'h4000;
    host_u.wr_reg(`PMCF_ADDR_TRIM, 8'h11);
    repeat (3) @(posedge sys_clk_i);
    `CHK(vref_scale_o, 16'h407b)
    margin_scale_i <= 16'h8000;
    repeat (3) @(posedge sys_clk_i);
    `CHK(vref_scale_o, 16'h80f6)
    margin_scale_i <= 16'h4000;
  endtask
  // Latch, hold, clear, re-set while present, clear by restart
  task automatic t_faults();
    n = alerts;
    fault_cond_i <= 4'h5;
    @(posedge sys_clk_i);
    fault_cond_i <= 4'h0;
    repeat (4) @(posedge sys_clk_i);
    `CHK({fault_flags_o, alert_o}, {4'h5, 1'b1})
    `CHK(alerts, n + 1)
    fault_cond_i <= 4'h2;
    clear_faults_i <= 1'b1;
    @(posedge sys_clk_i);
    clear_faults_i <= 1'b0;
    fault_cond_i <= 4'h0;
    repeat (2) @(posedge sys_clk_i);
    `CHK({fault_flags_o, alert_o}, {4'h2, 1'b1})
    clear_faults_i <= 1'b1;
    @(posedge sys_clk_i);
    clear_faults_i <= 1'b0;
    repeat (2) @(posedge sys_clk_i);
    `CHK({fault_flags_o, alert_o}, {4'h0, 1'b0})
    fault_cond_i <= 4'h8;
    @(posedge sys_clk_i);
    fault_cond_i <= 4'h0;
    repeat (2) @(posedge sys_clk_i);
    `CHK({fault_flags_o, alert_o}, {4'h8, 1'b1})
    `CHK(alerts, n + 2)
    en_i <= 1'b1;
    repeat (3) @(posedge sys_clk_i);
    `CHK({fault_flags_o, alert_o}, {4'h0, 1'b0})
    en_i <= 1'b0;
    repeat (3) @(posedge sys_clk_i);
  endtask
  // Power-on delay, ramp in DCM, FCCM after, latch-off on undervoltage
  task automatic t_seq();
    host_u.wr_reg(`PMCF_ADDR_DELAY, 8'h00);
    host_u.wr_reg(`PMCF_ADDR_MODE, 8'h03);
    en_i <= 1'b1;
    n = 0;
    while (switching_o !== 1'b1 && n < 400) begin
      @(posedge sys_clk_i);
      n++;
    end
    `CHK(n >= 354 && n <= 358, 1'b1)
    repeat (990) @(posedge sys_clk_i);
    `CHK({fccm_o, pgood_o}, 2'b00)
    n = 0;
    while (pgood_o !== 1'b1 && n < 400) begin
      @(posedge sys_clk_i);
      n++;
    end
    `CHK(n >= 260 && n <= 272, 1'b1)
    `CHK(fccm_o, 1'b1)
    uv_cond_i <= 1'b1;
    repeat (3) @(posedge sys_clk_i);
    uv_cond_i <= 1'b0;
    repeat (1200) @(posedge sys_clk_i);
    `CHK({switching_o, pgood_o}, 2'b00)
    en_i <= 1'b0;
  endtask
  // Supply cycle as a reset pulse: flags and scratch register back to defaults
  task automatic t_reset();
    fault_cond_i <= 4'h1;
    @(posedge sys_clk_i);
    fault_cond_i <= 4'h0;
    srst_i <= 1'b1;
    repeat (2) @(posedge sys_clk_i);
    srst_i <= 1'b0;
    `CHK({fault_flags_o, alert_o}, {4'h0, 1'b0})
    host_u.rd_reg(`PMCF_ADDR_SCRATCH, d, v);
    `CHK({v, d}, {1'b1, 8'h00})
  endtask
  // Undervoltage in run with hiccup response, default conduction mode
  task automatic t_hiccup();
    repeat (3) @(posedge sys_clk_i);
    host_u.wr_reg(`PMCF_ADDR_MODE, 8'h00);
    en_i <= 1'b1;
    n = 0;
    while (pgood_o !== 1'b1 && n < 2000) begin
      @(posedge sys_clk_i);
      n++;
    end
    `CHK({pgood_o, fccm_o}, 2'b10)
    uv_cond_i <= 1'b1;
    @(posedge sys_clk_i);
    uv_cond_i <= 1'b0;
    @(posedge sys_clk_i);
    `CHK({switching_o, pgood_o}, 2'b00)
    n = 0;
    // Restart after 8.96 ms plus seven 1 ms ramps
    while (switching_o !== 1'b1 && n < 16100) begin
      @(posedge sys_clk_i);
      n++;
    end
    `CHK(n >= 15958 && n <= 15962, 1'b1)
    en_i <= 1'b0;
    repeat (3) @(posedge sys_clk_i);
  endtask
  // Main sequence
  initial begin
    srst_i = 1'b1;
    clear_faults_i = 1'b0;
    en_i = 1'b0;
    fault_cond_i = 4'h0;
    uv_cond_i = 1'b0;
    margin_scale_i = 16'h4000;
    miscompares = 0;
    checked = 0;
    repeat (6) @(posedge sys_clk_i);
    srst_i <= 1'b0;
    t_defaults();
    t_rw();
    t_trim();
    t_faults();
    t_reset();
    t_seq();
    t_hiccup();
    summarize();
  end
  // Watchdog well beyond the expected 21000 cycles
  initial begin
    repeat (40000) @(posedge sys_clk_i);
    miscompares++;
    summarize();
  end
endmodule
